/* File: hw/uaf_pkg.sv */
package uaf_pkg;
  // Register byte addresses on the APB bus.
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_CTRL_C = 8'h08;
  localparam logic [7:0] ADDR_BAUD   = 8'h0C;
  localparam logic [7:0] ADDR_DATA   = 8'h10;
  // Field positions in ctrl_status_a.
  localparam int A_FILT = 0;
  localparam int A_DBL  = 1;
  localparam int A_PERR = 2;
  localparam int A_OVR  = 3;
  localparam int A_FERR = 4;
  localparam int A_TXE  = 5;
  localparam int A_TXC  = 6;
  localparam int A_RXC  = 7;
  // Field positions in ctrl_b and ctrl_c.
  localparam int B_TX9  = 0;
  localparam int B_RX9  = 1;
  localparam int B_CSZ2 = 2;
  localparam int B_TXEN = 3;
  localparam int B_RXEN = 4;
  localparam int C_CSZ0 = 1;
  localparam int C_STOP = 3;
  localparam int C_PM0  = 4;
  localparam int C_PM1  = 5;
  // Reset values, the nine-bit size code and widths.
  localparam logic [1:0] CSZ_LOW_RST = 2'h3;
  localparam logic [2:0] CSZ_NINE    = 3'h7;
  localparam int         BAUD_W      = 12;
  // Samples per bit and majority window per speed.
  localparam logic [4:0] SPB_NORM = 5'h10;
  localparam logic [4:0] SPB_DBL  = 5'h08;
  localparam logic [4:0] SF_NORM  = 5'h08;
  localparam logic [4:0] SF_DBL   = 5'h04;

  // Character size code to number of data bits.
  function automatic logic [3:0] uaf_char_bits(input logic [2:0] code);
    if (code == CSZ_NINE) begin
      uaf_char_bits = 4'h9;
    end else if (code[2]) begin
      uaf_char_bits = 4'h8;
    end else begin
      uaf_char_bits = 4'h5 + {2'h0, code[1:0]};
    end
  endfunction
endpackage

/* File: hw/uaf_cfg_if.sv */
interface uaf_cfg_if;
  logic       tick;
  logic       dbl;
  logic [3:0] nbits;
  logic       par_en;
  logic       par_odd;
  logic       two_stop;
  modport ctl  (output tick, dbl, nbits, par_en, par_odd, two_stop);
  modport core (input  tick, dbl, nbits, par_en, par_odd, two_stop);
endinterface

/* File: hw/uaf_rx.sv */
module uaf_rx (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Shared line settings.
  uaf_cfg_if.core         cfg,
  // Serial input and enable.
  input  wire logic       rx_en,
  input  wire logic       rxd,
  // Finished frame.
  output logic            fr_valid,
  output logic [8:0]      fr_data,
  output logic            fr_stop,
  output logic            fr_perr
);
  typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_BUSY = 1'b1} uaf_rx_e;
  uaf_rx_e    state_ff;
  logic       rxd_s1_ff, rxd_s2_ff;
  logic [4:0] cnt_ff;
  logic [3:0] bit_ff;
  logic [1:0] smp_ff;
  logic [8:0] shift_ff;
  logic       par_ff;
  logic [4:0] spb, sf;
  logic [3:0] par_idx, stop_idx, dat_idx;
  logic       vote;

  // Two-stage synchroniser for the serial pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_s1_ff <= 1'b1;
      rxd_s2_ff <= 1'b1;
    end else begin
      rxd_s1_ff <= rxd;
      rxd_s2_ff <= rxd_s1_ff;
    end
  end

  assign spb = cfg.dbl ? uaf_pkg::SPB_DBL : uaf_pkg::SPB_NORM;
  assign sf = cfg.dbl ? uaf_pkg::SF_DBL : uaf_pkg::SF_NORM;
  // data plus parity 5 to 10.
  assign par_idx  = cfg.nbits + 4'h1;
  assign stop_idx = par_idx + {3'h0, cfg.par_en};
  assign dat_idx  = bit_ff - 4'h1;
  assign vote = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & rxd_s2_ff) |
                (smp_ff[1] & rxd_s2_ff);

  // Bit recovery; the stop vote ends the frame so a new start may follow.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RX_IDLE;
      cnt_ff   <= 5'h00;
      bit_ff   <= 4'h0;
      smp_ff   <= 2'h0;
      shift_ff <= 9'h000;
      par_ff   <= 1'b0;
      fr_valid <= 1'b0;
      fr_data  <= 9'h000;
      fr_stop  <= 1'b0;
      fr_perr  <= 1'b0;
    end else begin
      fr_valid <= 1'b0;
      if (!rx_en) begin
        state_ff <= RX_IDLE;
      end else if (cfg.tick) begin
        unique case (state_ff)
          RX_IDLE: begin
            if (!rxd_s2_ff) begin
              state_ff <= RX_BUSY;
              cnt_ff   <= 5'h01;
              bit_ff   <= 4'h0;
              shift_ff <= 9'h000;
            end
          end
          RX_BUSY: begin
            cnt_ff <= (cnt_ff == spb) ? 5'h01 : cnt_ff + 5'h01;
            if (cnt_ff == spb) begin
              bit_ff <= bit_ff + 4'h1;
            end
            if (cnt_ff == sf) begin
              smp_ff[0] <= rxd_s2_ff;
            end
            if (cnt_ff == sf + 5'h01) begin
              smp_ff[1] <= rxd_s2_ff;
            end
            if (cnt_ff == sf + 5'h02) begin
              if (bit_ff == 4'h0) begin
                if (vote) begin
                  state_ff <= RX_IDLE;  // Noise spike, not a start.
                end
              end else if (bit_ff == stop_idx) begin
                state_ff <= RX_IDLE;
                fr_valid <= 1'b1;
                fr_data  <= shift_ff;
                fr_stop  <= vote;
                fr_perr  <= cfg.par_en & (^shift_ff ^ par_ff ^ cfg.par_odd);
              end else if (bit_ff == par_idx) begin
                par_ff <= vote;
              end else begin
                shift_ff[dat_idx] <= vote;
              end
            end
          end
        endcase
      end
    end
  end
endmodule  // uaf_rx

/* File: hw/uaf_tx.sv */
module uaf_tx (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Shared line settings.
  uaf_cfg_if.core         cfg,
  // Character hand-over.
  input  wire logic       load,
  input  wire logic [8:0] ld_data,
  output logic            busy,
  output logic            done,
  // Serial output.
  output logic            txd
);
  logic [10:0] sreg_ff;
  logic [3:0]  left_ff;
  logic [4:0]  cnt_ff;
  logic [4:0]  spb;
  logic [10:0] frame;

  assign spb = cfg.dbl ? uaf_pkg::SPB_DBL : uaf_pkg::SPB_NORM;

  // Data, then parity, then stop ones, sent least significant first.
  always_comb begin
    frame = '1;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(cfg.nbits)) begin
        frame[i] = ld_data[i];
      end
    end
    if (cfg.par_en) begin
      frame[cfg.nbits] = ^(ld_data & ~(9'h1FF << cfg.nbits)) ^ cfg.par_odd;
    end
  end

  // Shifter; it never looks at the address filter setting.
  // filter ignored here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sreg_ff <= '1;
      left_ff <= 4'h0;
      cnt_ff  <= 5'h00;
      busy    <= 1'b0;
      done    <= 1'b0;
      txd     <= 1'b1;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (load) begin
          busy    <= 1'b1;
          txd     <= 1'b0;
          sreg_ff <= frame;
          cnt_ff  <= 5'h01;
          left_ff <= cfg.nbits + {3'h0, cfg.par_en} +
                     (cfg.two_stop ? 4'h2 : 4'h1);
        end
      end else if (cfg.tick) begin
        cnt_ff <= (cnt_ff == spb) ? 5'h01 : cnt_ff + 5'h01;
        if (cnt_ff == spb) begin
          if (left_ff == 4'h0) begin
            busy <= 1'b0;
            done <= 1'b1;
          end else begin
            txd     <= sreg_ff[0];
            sreg_ff <= {1'b1, sreg_ff[10:1]};
            left_ff <= left_ff - 4'h1;
          end
        end
      end
    end
  end
endmodule  // uaf_tx

/* File: hw/uaf_top.sv */
// Added by the designer: the address map and the APB register port.
module uaf_top (
  // APB clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave port.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Serial pins.
  input  wire logic        rxd,
  output logic             txd
);
  uaf_cfg_if cfg_bus ();

  // Software settings.
  logic                      filt_ff;
  logic                      dbl_ff;
  logic                      rx_en_ff;
  logic                      tx_en_ff;
  logic [2:0]                csz_ff;
  logic                      tx9_ff;
  logic                      stop2_ff;
  logic [1:0]                pmode_ff;
  logic [uaf_pkg::BAUD_W-1:0] baud_ff;

  // Baud sample generator.
  logic [uaf_pkg::BAUD_W-1:0] bcnt_ff;
  logic                      tick;

  // Receive holding entry and flags.
  logic                      rxb_valid_ff;
  logic [8:0]                rxb_data_ff;
  logic                      rxb_ferr_ff;
  logic                      rxb_perr_ff;
  logic                      ovr_ff;

  // Transmit holding entry and flags.
  logic                      txb_full_ff;
  logic [8:0]                txb_data_ff;
  logic                      txc_ff;

  // Core hand-over signals.
  logic                      fr_valid;
  logic [8:0]                fr_data;
  logic                      fr_stop;
  logic                      fr_perr;
  logic                      tx_busy;
  logic                      tx_done;
  logic                      tx_load;

  // Bus decode.
  logic                      setup;
  logic                      access;
  logic                      wr;
  logic                      rd;
  logic                      hit;
  logic                      fr_type;
  logic                      fr_keep;
  logic                      pop;
  logic [31:0]               rd_mux;
  logic [31:0]               prdata_ff;
  logic                      pslverr_ff;

  // Address decode shared by read and write paths.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == uaf_pkg::ADDR_CTRL_A) || (a == uaf_pkg::ADDR_CTRL_B) ||
             (a == uaf_pkg::ADDR_CTRL_C) || (a == uaf_pkg::ADDR_BAUD) ||
             (a == uaf_pkg::ADDR_DATA);
  endfunction

  // Phase decode; the answer is given in the first access cycle.
  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign hit    = mapped(paddr);
  assign wr     = access & pwrite & hit & pstrb[0];
  assign rd     = access & ~pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  // Reading the data location releases the receive entry.
  assign pop = rd & (paddr == uaf_pkg::ADDR_DATA);

  assign cfg_bus.nbits    = uaf_pkg::uaf_char_bits(csz_ff);
  assign cfg_bus.dbl      = dbl_ff;
  assign cfg_bus.par_en   = pmode_ff[1];
  assign cfg_bus.par_odd  = pmode_ff[0];
  assign cfg_bus.two_stop = stop2_ff;
  assign cfg_bus.tick     = tick;

  // Sample tick every baud_divisor plus one clocks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_ff <= '0;
    end else if (bcnt_ff == '0) begin
      bcnt_ff <= baud_ff;
    end else begin
      bcnt_ff <= bcnt_ff - 1'b1;
    end
  end
  assign tick = (bcnt_ff == '0);

  // Frame type: ninth bit for nine-bit characters, else first stop.
  // first stop as type.
  assign fr_type = (csz_ff == uaf_pkg::CSZ_NINE) ? fr_data[8] : fr_stop;

  assign fr_keep = ~filt_ff | fr_type;

  // Receive entry; a new frame wins over a read in the same cycle.
  // address stored normally.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxb_valid_ff <= 1'b0;
      rxb_data_ff  <= 9'h000;
      rxb_ferr_ff  <= 1'b0;
      rxb_perr_ff  <= 1'b0;
    end else if (!rx_en_ff) begin
      rxb_valid_ff <= 1'b0;
      rxb_ferr_ff  <= 1'b0;
      rxb_perr_ff  <= 1'b0;
    end else if (fr_valid && fr_keep && (!rxb_valid_ff || pop)) begin
      rxb_valid_ff <= 1'b1;
      rxb_data_ff  <= fr_data;
      rxb_ferr_ff  <= ~fr_stop;
      rxb_perr_ff  <= fr_perr;
    end else if (pop) begin
      rxb_valid_ff <= 1'b0;
    end
  end

  // Overrun: a kept frame found the entry still unread and was lost.
  // no overrun when dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_ff <= 1'b0;
    end else if (!rx_en_ff) begin
      ovr_ff <= 1'b0;
    end else if (fr_valid && fr_keep) begin
      ovr_ff <= rxb_valid_ff & ~pop;
    end
  end

  // Transmit entry: a write to the data location fills it when empty.
  // Loading on a sample tick keeps the start bit a full bit time long.
  assign tx_load = txb_full_ff & tx_en_ff & ~tx_busy & tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txb_full_ff <= 1'b0;
      txb_data_ff <= 9'h000;
    end else if (wr && paddr == uaf_pkg::ADDR_DATA && !txb_full_ff) begin
      txb_full_ff <= 1'b1;
      txb_data_ff <= {tx9_ff, pwdata[7:0]};
    end else if (tx_load) begin
      txb_full_ff <= 1'b0;
    end
  end

  // Transmit complete: set when the line goes idle with nothing queued.
  // A write of one clears it, but a completion in that cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txc_ff <= 1'b0;
    end else if (tx_done && !txb_full_ff) begin
      txc_ff <= 1'b1;
    end else if (wr && paddr == uaf_pkg::ADDR_CTRL_A &&
                 pwdata[uaf_pkg::A_TXC]) begin
      txc_ff <= 1'b0;
    end
  end

  // Settings in ctrl_status_a and ctrl_b, plus the low size bits of ctrl_c.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_ff  <= 1'b0;
      dbl_ff   <= 1'b0;
      rx_en_ff <= 1'b0;
      tx_en_ff <= 1'b0;
      csz_ff   <= {1'b0, uaf_pkg::CSZ_LOW_RST};
      tx9_ff   <= 1'b0;
    end else if (wr && paddr == uaf_pkg::ADDR_CTRL_A) begin
      filt_ff <= pwdata[uaf_pkg::A_FILT];
      dbl_ff  <= pwdata[uaf_pkg::A_DBL];
    end else if (wr && paddr == uaf_pkg::ADDR_CTRL_B) begin
      rx_en_ff  <= pwdata[uaf_pkg::B_RXEN];
      tx_en_ff  <= pwdata[uaf_pkg::B_TXEN];
      csz_ff[2] <= pwdata[uaf_pkg::B_CSZ2];
      tx9_ff    <= pwdata[uaf_pkg::B_TX9];
    end else if (wr && paddr == uaf_pkg::ADDR_CTRL_C) begin
      csz_ff[1:0] <= pwdata[uaf_pkg::C_CSZ0 +: 2];
    end
  end

  // Settings in ctrl_c and the baud divisor.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop2_ff <= 1'b0;
      pmode_ff <= 2'h0;
      baud_ff  <= '0;
    end else if (wr && paddr == uaf_pkg::ADDR_CTRL_C) begin
      stop2_ff <= pwdata[uaf_pkg::C_STOP];
      pmode_ff <= {pwdata[uaf_pkg::C_PM1], pwdata[uaf_pkg::C_PM0]};
    end else if (wr && paddr == uaf_pkg::ADDR_BAUD) begin
      baud_ff[7:0] <= pwdata[7:0];
      if (pstrb[1]) begin
        baud_ff[uaf_pkg::BAUD_W-1:8] <= pwdata[uaf_pkg::BAUD_W-1:8];
      end
    end
  end

  // Read view of every register; unused bits read zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      uaf_pkg::ADDR_CTRL_A: begin
        rd_mux[uaf_pkg::A_FILT] = filt_ff;
        rd_mux[uaf_pkg::A_DBL]  = dbl_ff;
        rd_mux[uaf_pkg::A_PERR] = rxb_valid_ff & rxb_perr_ff;
        rd_mux[uaf_pkg::A_OVR]  = ovr_ff;
        rd_mux[uaf_pkg::A_FERR] = rxb_valid_ff & rxb_ferr_ff;
        rd_mux[uaf_pkg::A_TXE]  = ~txb_full_ff;
        rd_mux[uaf_pkg::A_TXC]  = txc_ff;
        rd_mux[uaf_pkg::A_RXC]  = rxb_valid_ff;
      end
      uaf_pkg::ADDR_CTRL_B: begin
        rd_mux[uaf_pkg::B_RXEN] = rx_en_ff;
        rd_mux[uaf_pkg::B_TXEN] = tx_en_ff;
        rd_mux[uaf_pkg::B_CSZ2] = csz_ff[2];
        rd_mux[uaf_pkg::B_RX9]  = rxb_data_ff[8];
        rd_mux[uaf_pkg::B_TX9]  = tx9_ff;
      end
      uaf_pkg::ADDR_CTRL_C: begin
        rd_mux[uaf_pkg::C_CSZ0 +: 2] = csz_ff[1:0];
        rd_mux[uaf_pkg::C_STOP]      = stop2_ff;
        rd_mux[uaf_pkg::C_PM0]       = pmode_ff[0];
        rd_mux[uaf_pkg::C_PM1]       = pmode_ff[1];
      end
      uaf_pkg::ADDR_BAUD: begin
        rd_mux[uaf_pkg::BAUD_W-1:0] = baud_ff;
      end
      uaf_pkg::ADDR_DATA: begin
        rd_mux[7:0] = rxb_data_ff[7:0];
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_ff <= ~hit;
    end
  end

  // Receiver core.
  uaf_rx u_rx (
    .pclk     (pclk),
    .presetn  (presetn),
    .cfg      (cfg_bus.core),
    .rx_en    (rx_en_ff),
    .rxd      (rxd),
    .fr_valid (fr_valid),
    .fr_data  (fr_data),
    .fr_stop  (fr_stop),
    .fr_perr  (fr_perr)
  );

  // Transmitter core.
  uaf_tx u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (cfg_bus.core),
    .load    (tx_load),
    .ld_data (txb_data_ff),
    .busy    (tx_busy),
    .done    (tx_done),
    .txd     (txd)
  );
endmodule  // uaf_top

/* File: verif/uaf_monitor.sv */
module uaf_monitor (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave port.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Serial pins.
  input wire logic        rxd,
  input wire logic        txd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        filt_ff;
  logic        dbl_ff;
  logic        csz2_ff;
  logic [1:0]  csz_ff;
  logic [11:0] baud_ff;
  logic [15:0] low_ff;
  logic        wr;
  logic        rd;
  logic [15:0] bit_len;

  // Bus write and read in their access cycle.
  assign wr = psel && penable && pwrite && pstrb[0];
  assign rd = psel && penable && !pwrite;
  // Clocks per serial bit from the shadowed settings.
  assign bit_len = ({4'h0, baud_ff} + 16'h0001) << (dbl_ff ? 3 : 4);

  // Shadow of the settings that software writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_ff <= 1'b0;
      dbl_ff <= 1'b0;
      csz2_ff <= 1'b0;
      csz_ff <= uaf_pkg::CSZ_LOW_RST;
      baud_ff <= 12'h000;
    end else if (wr) begin
      if (paddr == uaf_pkg::ADDR_CTRL_A) begin
        filt_ff <= pwdata[uaf_pkg::A_FILT];
        dbl_ff <= pwdata[uaf_pkg::A_DBL];
      end
      if (paddr == uaf_pkg::ADDR_CTRL_B) begin
        csz2_ff <= pwdata[uaf_pkg::B_CSZ2];
      end
      if (paddr == uaf_pkg::ADDR_CTRL_C) begin
        csz_ff <= pwdata[2:1];
      end
      if (paddr == uaf_pkg::ADDR_BAUD) begin
        baud_ff[7:0] <= pwdata[7:0];
        baud_ff[11:8] <= pstrb[1] ? pwdata[11:8] : baud_ff[11:8];
      end
    end
  end

  // Length of the current low run on the transmit pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_ff <= 16'h0000;
    end else begin
      low_ff <= txd ? 16'h0000 : low_ff + 16'h0001;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
  a_unmapped_err: assert property (psel && penable &&
    paddr > uaf_pkg::ADDR_DATA |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && paddr[1:0] == 2'h0 &&
    paddr <= uaf_pkg::ADDR_DATA |-> !pslverr)
    else $error("mapped access refused");
  a_filt_readback: assert property (
    rd && paddr == uaf_pkg::ADDR_CTRL_A |-> prdata[uaf_pkg::A_FILT] == filt_ff)
    else $error("filter bit lost");
  a_speed_readback: assert property (
    rd && paddr == uaf_pkg::ADDR_CTRL_A |-> prdata[uaf_pkg::A_DBL] == dbl_ff)
    else $error("speed bit lost");
  a_size_low_read: assert property (
    rd && paddr == uaf_pkg::ADDR_CTRL_C |-> prdata[2:1] == csz_ff)
    else $error("size low bits lost");
  a_size_high_read: assert property (
    rd && paddr == uaf_pkg::ADDR_CTRL_B |-> prdata[uaf_pkg::B_CSZ2] == csz2_ff)
    else $error("size high bit lost");
  a_baud_readback: assert property (
    rd && paddr == uaf_pkg::ADDR_BAUD |-> prdata[11:0] == baud_ff)
    else $error("divisor lost");
  a_tx_bit_time: assert property (
    $rose(txd) |-> low_ff % bit_len == 16'h0000)
    else $error("transmit bit length wrong");

  c_unmapped: cover property (psel && penable && paddr > uaf_pkg::ADDR_DATA);
  c_data_read: cover property (rd && paddr == uaf_pkg::ADDR_DATA);
  c_tx_frame: cover property ($fell(txd));
endmodule // uaf_monitor

/* File: verif/uaf_far_master.sv */
module uaf_far_master (
  // Clock.
  input wire logic pclk,
  // Serial line toward the receiver, idle high.
  output logic     rxd
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line idles high between frames.
  initial rxd = 1'b1;

  // Sends one frame; an optional one-clock glitch sits mid data bit.
  task automatic send(input logic [9:0] bits, input int n, input logic kind,
                      input int cpb, input logic glitch);
    logic [12:0] fr;
    fr = 13'h1FFF;
    fr[0] = 1'b0;
    for (int i = 0; i < n; i++) begin
      fr[i + 1] = bits[i];
    end
    if (n >= 9) begin
      fr[9] = kind;
    end else begin
      fr[n + 1] = kind;
    end
    for (int i = 0; i < n + 3; i++) begin
      for (int c = 0; c < cpb; c++) begin
        @(posedge pclk);
        rxd <= (glitch && c == cpb / 2 && i > 0 && i <= n) ? !fr[i] : fr[i];
      end
    end
  endtask
endmodule // uaf_far_master

/* File: verif/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rxd, txd, er;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd;
  int          err_count, samples_checked;

  uaf_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rxd(rxd), .txd(txd));
  uaf_far_master far_u (.pclk(pclk), .rxd(rxd));

  // Clock of 10 ns period.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // One APB transfer, held until ready is seen high.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Compares one word and counts the result.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads a register and compares the masked bits.
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] m,
                            input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(rd & m, exp);
  endtask

  // Reset values and the refused address.
  task automatic test_reset_values();
    expect_reg(uaf_pkg::ADDR_CTRL_A, 32'hDF, 32'h00);
    expect_reg(uaf_pkg::ADDR_CTRL_C, 32'hFF, 32'h06);
    expect_reg(uaf_pkg::ADDR_BAUD, 32'hFFF, 32'h0);
    xfer(8'h14, 1'b1, 32'hFFFF_FFFF);
    check({31'h0, er}, 32'h1);
    expect_reg(8'h14, 32'hFFFF_FFFF, 32'h0);
  endtask

  // Nine-bit addressed exchange with the filter toggled.
  task automatic test_nine_bit_filter();
    xfer(uaf_pkg::ADDR_BAUD, 1'b1, 32'h1);
    xfer(uaf_pkg::ADDR_CTRL_B, 1'b1, 32'h1C);
    xfer(uaf_pkg::ADDR_CTRL_A, 1'b1, 32'h1);
    far_u.send(10'h033, 9, 1'b0, 32, 1'b0);
    expect_reg(uaf_pkg::ADDR_CTRL_A, 32'h9C, 32'h00);
    far_u.send(10'h0A5, 9, 1'b1, 32, 1'b0);
    expect_reg(uaf_pkg::ADDR_CTRL_A, 32'h80, 32'h80);
    expect_reg(uaf_pkg::ADDR_CTRL_B, 32'h02, 32'h02);
    expect_reg(uaf_pkg::ADDR_DATA, 32'hFF, 32'hA5);
    xfer(uaf_pkg::ADDR_CTRL_A, 1'b1, 32'h0);
    far_u.send(10'h13C, 9, 1'b0, 32, 1'b0);
    expect_reg(uaf_pkg::ADDR_CTRL_B, 32'h02, 32'h00);
    expect_reg(uaf_pkg::ADDR_DATA, 32'hFF, 32'h3C);
    xfer(uaf_pkg::ADDR_CTRL_A, 1'b1, 32'h1);
    far_u.send(10'h055, 9, 1'b0, 32, 1'b0);
    expect_reg(uaf_pkg::ADDR_CTRL_A, 32'h80, 32'h00);
  endtask

  // Eight-bit frames typed by their first stop bit.
  task automatic test_eight_bit_filter();
    xfer(uaf_pkg::ADDR_CTRL_B, 1'b1, 32'h18);
    far_u.send(10'h0C3, 8, 1'b0, 32, 1'b0);
    expect_reg(uaf_pkg::ADDR_CTRL_A, 32'h9C, 32'h00);
    far_u.send(10'h0C3, 8, 1'b1, 32, 1'b0);
    expect_reg(uaf_pkg::ADDR_CTRL_A, 32'h9C, 32'h80);
    expect_reg(uaf_pkg::ADDR_DATA, 32'hFF, 32'hC3);
    xfer(uaf_pkg::ADDR_CTRL_A, 1'b1, 32'h0);
    far_u.send(10'h05A, 8, 1'b0, 32, 1'b0);
    expect_reg(uaf_pkg::ADDR_CTRL_A, 32'h9C, 32'h90);
    expect_reg(uaf_pkg::ADDR_DATA, 32'hFF, 32'h5A);
  endtask

  // Double speed, every size and a parity frame, all with glitches.
  task automatic test_speed_and_size();
    logic [9:0] v;
    xfer(uaf_pkg::ADDR_CTRL_A, 1'b1, 32'h2);
    for (int k = 0; k < 4; k++) begin
      xfer(uaf_pkg::ADDR_CTRL_C, 1'b1, 32'(k) << 1);
      far_u.send(10'h0B5, 5 + k, 1'b1, 16, 1'b1);
      v = 10'h0B5 & ((10'h001 << (5 + k)) - 10'h001);
      expect_reg(uaf_pkg::ADDR_DATA, 32'hFF, {22'h0, v});
    end
    xfer(uaf_pkg::ADDR_CTRL_B, 1'b1, 32'h1C);
    xfer(uaf_pkg::ADDR_CTRL_C, 1'b1, 32'h26);
    far_u.send({^9'h1C6, 9'h1C6}, 10, 1'b1, 16, 1'b1);
    expect_reg(uaf_pkg::ADDR_CTRL_A, 32'h9C, 32'h80);
    expect_reg(uaf_pkg::ADDR_DATA, 32'hFF, 32'hC6);
    xfer(uaf_pkg::ADDR_CTRL_C, 1'b1, 32'h06);
  endtask

  // Nine-bit transmit with the filter on, then the done flag.
  task automatic test_transmit();
    logic [10:0] got;
    int          n;
    xfer(uaf_pkg::ADDR_CTRL_A, 1'b1, 32'h1);
    xfer(uaf_pkg::ADDR_CTRL_B, 1'b1, 32'h1D);
    xfer(uaf_pkg::ADDR_DATA, 1'b1, 32'h5C);
    n = 0;
    while (txd !== 1'b0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n < 2000), 32'h1);
    repeat (16) @(posedge pclk);
    for (int i = 0; i < 11; i++) begin
      got[i] = txd;
      repeat (32) @(posedge pclk);
    end
    check({21'h0, got}, {21'h0, 1'b1, 1'b1, 8'h5C, 1'b0});
    expect_reg(uaf_pkg::ADDR_CTRL_A, 32'h41, 32'h41);
    xfer(uaf_pkg::ADDR_CTRL_A, 1'b1, 32'h41);
    expect_reg(uaf_pkg::ADDR_CTRL_A, 32'h41, 32'h01);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence after a reset of four cycles.
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    test_reset_values();
    test_nine_bit_filter();
    test_eight_bit_filter();
    test_speed_and_size();
    test_transmit();
    print_verdict();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #500000;
    err_count++;
    print_verdict();
  end
endmodule // testbench

bind uaf_top uaf_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .rxd(rxd), .txd(txd));
